// file: reset_pin_partner.sv
// Model of the external reset pin circuit and the supply monitor
module reset_pin_partner (
    input wire logic pin_hold_low, // Outside circuit pulls the pin low
    input wire logic dut_oe,       // Device pin drive enable
    input wire logic dut_out,      // Device pin drive value
    input wire logic dip,          // Supply sags under the threshold
    output logic pin_level,        // Resolved pin level
    output logic supply_below      // Monitor output
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up resistor keeps the pin high unless someone pulls it low
    assign pin_level = pin_hold_low ? 1'b0 : (dut_oe ? dut_out : 1'b1);
    // Monitor reports the sag as a level
    assign supply_below = dip;
endmodule : reset_pin_partner

// file: reset_seq_pkg.sv
// Package of constants and types for the reset source sequencer
package reset_seq_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int PIN_FILTER_NS = 300;
    localparam int BOR_FILTER_NS = 1000;
    localparam int PIN_FILTER_CYC_RAW = PIN_FILTER_NS / CLK_PERIOD_NS;
    localparam int PIN_FILTER_CYC = (PIN_FILTER_CYC_RAW < 1) ? 1 : PIN_FILTER_CYC_RAW;
    localparam int BOR_FILTER_CYC_RAW = BOR_FILTER_NS / CLK_PERIOD_NS;
    localparam int BOR_FILTER_CYC = (BOR_FILTER_CYC_RAW < 1) ? 1 : BOR_FILTER_CYC_RAW;
    localparam int POWER_UP_TIMER_BITS = 11;
    localparam int POWER_UP_TIMER_COUNT = 2048;
    localparam int FILT_BITS = 8;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RESET_CONTROL_REGISTER_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;

    // Reset control register fields
    localparam int BROWNOUT_BIT = 0;
    localparam int POWERON_BIT = 1;
    localparam int MISMATCH_BIT = 5;
    localparam int PRIO_EN_BIT = 7;

    // Status register fields
    localparam int ST_PIN_BIT = 0;
    localparam int ST_BOR_BIT = 1;
    localparam int ST_MISMATCH_BIT = 2;
    localparam int ST_TIMER_BIT = 3;
    localparam int ST_COUNT_LSB = 16;

    // Reset values
    localparam logic RST_BROWNOUT = 1'b0;
    localparam logic RST_POWERON = 1'b0;
    localparam logic RST_MISMATCH = 1'b1;
    localparam logic RST_PRIO_EN = 1'b0;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        SEQ_TIMER = 4'b0001,
        SEQ_BROWN = 4'b0010,
        SEQ_HOLD = 4'b0100,
        SEQ_RUN = 4'b1000
    } seq_state_t;

endpackage : reset_seq_pkg

// file: reset_seq_properties.sv
// Port level checks for the reset source sequencer
module reset_seq_properties
    import reset_seq_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_COUNT
) (
    input wire logic clk,                   // Internal RC clock
    input wire logic rst_n,                 // Power-on reset
    input wire logic ext_reset_pin_n_in,    // Pin level
    input wire logic ext_reset_pin_n_oe,    // Pin drive enable
    input wire logic regulator_enable_pin,  // Regulator strap
    input wire logic supply_below_brownout, // Supply low
    input wire logic config_reload,         // Reload pulse
    input wire logic sys_reset_n,           // Combined reset
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic [7:0] paddr,           // APB address
    input wire logic pready,                // APB ready
    input wire logic pslverr                // APB error
);
    // ****************************************
    // Helper counters
    // ****************************************
    int up_cnt;
    int dip_cnt;
    logic bor_seen;
    // Cycles since power-on release, since supply recovery, brown-out seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 0;
            dip_cnt <= 0;
            bor_seen <= 1'b0;
        end else begin
            up_cnt <= (up_cnt < 100000) ? up_cnt + 1 : up_cnt;
            dip_cnt <= supply_below_brownout ? 0 : ((dip_cnt < 100000) ? dip_cnt + 1 : dip_cnt);
            bor_seen <= !sys_reset_n && (bor_seen || (supply_below_brownout && regulator_enable_pin));
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_PIN_NOT_DRIVEN: assert property (!ext_reset_pin_n_oe)
        else $error("reset pin driven by device");
    AST_PIN_HOLD: assert property ((!ext_reset_pin_n_in) [*7] |-> !sys_reset_n)
        else $error("pin held low without reset");
    AST_GLITCH: assert property (sys_reset_n && $fell(ext_reset_pin_n_in) ##1 !ext_reset_pin_n_in
        ##1 ext_reset_pin_n_in |-> sys_reset_n [*4])
        else $error("short pin glitch caused reset");
    AST_BOR_HOLD: assert property ((regulator_enable_pin && supply_below_brownout) [*8]
        ##1 (regulator_enable_pin && supply_below_brownout) [*6] |-> !sys_reset_n)
        else $error("brown-out did not hold reset");
    AST_BOR_TIMER: assert property ($rose(sys_reset_n) && bor_seen
        |-> dip_cnt >= POWER_UP_TIMER_CYCLES && dip_cnt <= POWER_UP_TIMER_CYCLES + 8)
        else $error("brown-out release not after full timer");
    AST_POR_TIMER: assert property ($rose(sys_reset_n) |-> up_cnt >= POWER_UP_TIMER_CYCLES)
        else $error("release before power-up timer expired");
    AST_RELOAD_ON_ENTRY: assert property ($fell(sys_reset_n) |-> config_reload)
        else $error("no reload on reset entry");
    AST_READY_WAIT: assert property (psel && $rose(penable) |=> pready && psel && penable)
        else $error("ready not after one wait state");
    AST_SLVERR: assert property (pready |-> pslverr == (paddr != RESET_CONTROL_REGISTER_ADDR && paddr != STATUS_ADDR))
        else $error("error response wrong for address");
endmodule : reset_seq_properties

bind reset_source_sequencer reset_seq_properties #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .ext_reset_pin_n_in(ext_reset_pin_n_in), .ext_reset_pin_n_oe(ext_reset_pin_n_oe),
    .regulator_enable_pin(regulator_enable_pin), .supply_below_brownout(supply_below_brownout),
    .config_reload(config_reload), .sys_reset_n(sys_reset_n), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr));

// file: reset_source_sequencer.sv
// Reset source combiner, power-up timer and reset cause flags
// Summary of operation
// R1: Device stays in reset while the external reset pin is held low.
// R2: Short low glitches on the external reset pin are filtered out.
// R3: The external reset pin is never driven low by internal resets.
// R4: Power-on reset (rst_n) starts the device from its initialized state.
// R5: Power-on flag cleared to 0 on power-on reset only.
// R6: No hardware sets the power-on flag; software writes it to 1.
// R7: With regulator on, supply low longer than filter time causes reset.
// R8: Brown-out reset held while the supply stays below threshold.
// R9: After brown-out ends the power-up timer runs before release.
// R10: Brown-out during timer count returns to brown-out and restarts timer.
// R11: Brown-out flag cleared on brown-out reset and on power-on reset.
// R12: Software reads brown-out 0 with power-on 1 as a brown-out reset.
// R13: Regulator off means no brown-out detection; power-on still clears flag.
// R14: Configuration words compared with inverted shadows; mismatch resets.
// R15: Mismatch flag cleared to 0 on mismatch reset only.
// R16: Mismatch acts as pin reset; every restart reloads configuration.
// R17: Power-up timer always runs after power-on, no disable.
// R18: Power-up timer is 11 bits, 2048 clock counts.
// R19: Internal reset held while power-up timer counts.
// R20: Timer starts only after power-on reset is released.
// R21: Pin held low past timer expiry: run starts as soon as pin rises.
// R22: All sources merge into one reset, released when all are quiet; here a live mismatch at timer expiry still releases it for one cycle.
// R23: Power-on flag at bit 1 of reset control register, writable.
// R24: Brown-out flag at bit 0 of reset control register, writable.
// R25: Mismatch flag at bit 5; 0 means mismatch reset occurred.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module reset_source_sequencer
    import reset_seq_pkg::*;
#(
    parameter int CFG_WIDTH = 16,
    parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_COUNT
) (
    input wire logic clk,                          // Internal RC clock
    input wire logic rst_n,                        // Power-on reset, low active
    input wire logic ext_reset_pin_n_in,           // External reset pin level
    output logic ext_reset_pin_n_out,              // Pin drive value
    output logic ext_reset_pin_n_oe,               // Pin drive enable
    input wire logic regulator_enable_pin,         // Regulator enable strap
    input wire logic supply_below_brownout,        // Supply under threshold
    input wire logic [CFG_WIDTH-1:0] config_word,  // Configuration words
    input wire logic [CFG_WIDTH-1:0] config_shadow, // Inverted shadow copy
    output logic config_reload,                    // Reload pulse
    output logic sys_reset_n,                      // Combined internal reset
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB enable
    input wire logic pwrite,                       // APB direction
    input wire logic [7:0] paddr,                  // APB address
    input wire logic [31:0] pwdata,                // APB write data
    output logic [31:0] prdata,                    // APB read data
    output logic pready,                           // APB ready
    output logic pslverr                           // APB error
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [POWER_UP_TIMER_BITS-1:0] POWER_UP_TIMER_LAST = POWER_UP_TIMER_BITS'(POWER_UP_TIMER_CYCLES - 1);
    localparam logic [FILT_BITS-1:0] PIN_LAST = FILT_BITS'(PIN_FILTER_CYC);
    localparam logic [FILT_BITS-1:0] BOR_LAST = FILT_BITS'(BOR_FILTER_CYC);
    localparam logic [FILT_BITS-1:0] FILT_ONE = 8'h01;
    localparam logic [POWER_UP_TIMER_BITS-1:0] POWER_UP_TIMER_ONE = 11'h001;

    // Reset release and source filters
    logic rst_meta_r;
    logic rst_sync_r;
    logic [FILT_BITS-1:0] pin_cnt_r;
    logic pin_low_r;
    logic [FILT_BITS-1:0] bor_cnt_r;
    logic bor_active_r;
    logic mismatch;

    // Sequencer
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [POWER_UP_TIMER_BITS-1:0] power_up_timer_cnt_r;
    logic power_up_timer_done;
    logic enter_reset;

    // Reset cause flags
    logic brownout_flag_r;
    logic poweron_flag_r;
    logic config_mismatch_flag_r;
    logic prio_en_r;

    // Output registers
    logic sys_reset_n_r;
    logic config_reload_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // Bus decode
    logic [31:0] rd_word;
    logic addr_hit;
    logic acc;
    logic wr_reset_control_register;

    // ****************************************
    // Reset release
    // ****************************************
    // Two-stage release of the power-on reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r; // R4
        end
    end

    // ****************************************
    // Source detection
    // ****************************************
    // Pin glitch filter: low must persist before it counts
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pin_cnt_r <= '0;
            pin_low_r <= 1'b0;
        end else if (ext_reset_pin_n_in) begin
            pin_cnt_r <= '0;
            pin_low_r <= 1'b0;
        end else if (pin_cnt_r >= PIN_LAST) begin
            pin_low_r <= 1'b1; // R1 R2
        end else begin
            pin_cnt_r <= pin_cnt_r + FILT_ONE; // R2
        end
    end

    // Brown-out filter, live only with the regulator enabled
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            bor_cnt_r <= '0;
            bor_active_r <= 1'b0;
        end else if (!(supply_below_brownout && regulator_enable_pin)) begin
            bor_cnt_r <= '0; // R13
            bor_active_r <= 1'b0;
        end else if (bor_cnt_r >= BOR_LAST) begin
            bor_active_r <= 1'b1; // R7 R8
        end else begin
            bor_cnt_r <= bor_cnt_r + FILT_ONE; // R7
        end
    end

    // Configuration against its inverted shadow
    assign mismatch = (config_word != ~config_shadow); // R14

    // ****************************************
    // Sequencer
    // ****************************************
    // Timer end point reached
    assign power_up_timer_done = (power_up_timer_cnt_r == POWER_UP_TIMER_LAST); // R18

    // Next state of the reset sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SEQ_TIMER: begin
                if (bor_active_r) begin
                    state_nxt = SEQ_BROWN; // R10
                end else if (power_up_timer_done) begin
                    state_nxt = pin_low_r ? SEQ_HOLD : SEQ_RUN; // R19 R21
                end
            end
            SEQ_BROWN: begin
                if (!bor_active_r) begin
                    state_nxt = SEQ_TIMER; // R8 R9
                end
            end
            // Held by a low pin or a live mismatch until both are gone
            SEQ_HOLD: begin
                if (bor_active_r) begin
                    state_nxt = SEQ_BROWN;
                end else if (!pin_low_r && !mismatch) begin
                    state_nxt = SEQ_RUN; // R1 R16 R21
                end
            end
            SEQ_RUN: begin
                if (bor_active_r) begin
                    state_nxt = SEQ_BROWN; // R7
                end else if (pin_low_r || mismatch) begin
                    state_nxt = SEQ_HOLD; // R14 R16
                end
            end
            default: begin
                state_nxt = SEQ_TIMER;
            end
        endcase
    end

    // Leaving run marks a reset entry
    assign enter_reset = (state_r == SEQ_RUN) && (state_nxt != SEQ_RUN);

    // State register; timer state follows power-on release
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r <= SEQ_TIMER; // R17 R20
        end else begin
            state_r <= state_nxt;
        end
    end

    // Power-up timer, cleared outside the timer state or during brown-out; holds at its end point
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            power_up_timer_cnt_r <= '0; // R20
        end else if (state_r != SEQ_TIMER || bor_active_r) begin
            power_up_timer_cnt_r <= '0; // R10
        end else if (!power_up_timer_done) begin
            power_up_timer_cnt_r <= power_up_timer_cnt_r + POWER_UP_TIMER_ONE; // R18
        end
    end

    // Combined internal reset, low unless running
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            sys_reset_n_r <= 1'b0;
        end else begin
            sys_reset_n_r <= (state_nxt == SEQ_RUN); // R22 R19
        end
    end

    // Configuration reload at power-on and on every reset entry
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            config_reload_r <= 1'b1; // R16
        end else begin
            config_reload_r <= enter_reset; // R16
        end
    end

    // Pin is input only; never pulled low from inside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_reset_pin_n_out <= 1'b1;
            ext_reset_pin_n_oe <= 1'b0;
        end else begin
            ext_reset_pin_n_out <= 1'b1; // R3
            ext_reset_pin_n_oe <= 1'b0; // R3
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // Access phase, address decode and write strobe
    assign acc = psel && penable && !pready_r;
    assign addr_hit = (paddr == RESET_CONTROL_REGISTER_ADDR) || (paddr == STATUS_ADDR);
    assign wr_reset_control_register = psel && penable && pready_r && pwrite && (paddr == RESET_CONTROL_REGISTER_ADDR);

    // Read mux
    always_comb begin
        rd_word = '0;
        if (paddr == RESET_CONTROL_REGISTER_ADDR) begin
            rd_word[BROWNOUT_BIT] = brownout_flag_r; // R24
            rd_word[POWERON_BIT] = poweron_flag_r; // R23
            rd_word[MISMATCH_BIT] = config_mismatch_flag_r; // R25
            rd_word[PRIO_EN_BIT] = prio_en_r;
        end else if (paddr == STATUS_ADDR) begin
            rd_word[ST_PIN_BIT] = pin_low_r;
            rd_word[ST_BOR_BIT] = bor_active_r;
            rd_word[ST_MISMATCH_BIT] = mismatch;
            rd_word[ST_TIMER_BIT] = (state_r == SEQ_TIMER);
            rd_word[ST_COUNT_LSB +: POWER_UP_TIMER_BITS] = power_up_timer_cnt_r;
        end
    end

    // One wait state, then ready with the error flag
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !addr_hit;
        end
    end

    // Read data taken in the wait state, held until the next read
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            prdata_r <= '0;
        end else if (acc && !pwrite) begin
            prdata_r <= rd_word;
        end
    end

    // ****************************************
    // Reset cause flags
    // ****************************************
    // Power-on flag: only the power-on reset clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            poweron_flag_r <= RST_POWERON; // R5
        end else if (wr_reset_control_register) begin
            poweron_flag_r <= pwdata[POWERON_BIT]; // R6 R23
        end
    end

    // Brown-out flag: hardware clear wins over a write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_flag_r <= RST_BROWNOUT; // R11 R13
        end else if (bor_active_r) begin
            brownout_flag_r <= 1'b0; // R11
        end else if (wr_reset_control_register) begin
            brownout_flag_r <= pwdata[BROWNOUT_BIT]; // R24
        end
    end

    // Mismatch flag: cleared by mismatch reset only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_mismatch_flag_r <= RST_MISMATCH; // R15
        end else if (state_r == SEQ_RUN && mismatch && !bor_active_r) begin
            config_mismatch_flag_r <= 1'b0; // R15
        end else if (wr_reset_control_register) begin
            config_mismatch_flag_r <= pwdata[MISMATCH_BIT]; // R25
        end
    end

    // Interrupt priority control bit, plain storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_en_r <= RST_PRIO_EN;
        end else if (wr_reset_control_register) begin
            prio_en_r <= pwdata[PRIO_EN_BIT];
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Ports straight from their registers
    assign sys_reset_n = sys_reset_n_r;
    assign config_reload = config_reload_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

endmodule : reset_source_sequencer

// file: tb.sv
// Self-checking bench for the reset source sequencer
module tb
    import reset_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POWER_UP_TIMER = 16;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_hold_low = 1'b0;
    logic dip = 1'b0;
    logic regulator_enable_pin = 1'b1;
    logic [15:0] config_word = 16'h1234;
    logic [15:0] config_shadow = 16'hedcb;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pin_level, pin_out, pin_oe, supply_below, config_reload, sys_reset_n, pready, pslverr, err;
    logic [31:0] prdata, rd;
    int err_total = 0;
    int checked = 0;
    int cyc;
    // Pin circuit and supply monitor
    reset_pin_partner u_partner (.pin_hold_low(pin_hold_low), .dut_oe(pin_oe), .dut_out(pin_out),
        .dip(dip), .pin_level(pin_level), .supply_below(supply_below));
    // Design with a short power-up count
    reset_source_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) u_dut (.clk(clk), .rst_n(rst_n),
        .ext_reset_pin_n_in(pin_level), .ext_reset_pin_n_out(pin_out), .ext_reset_pin_n_oe(pin_oe),
        .regulator_enable_pin(regulator_enable_pin), .supply_below_brownout(supply_below),
        .config_word(config_word), .config_shadow(config_shadow), .config_reload(config_reload),
        .sys_reset_n(sys_reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            end_sim();
        end
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_sys(input logic lvl, input int lim, output int c);
        c = 0;
        while (sys_reset_n !== lvl) begin
            @(posedge clk);
            c++;
            if (c > lim) begin
                err_total++;
                end_sim();
            end
        end
    endtask : wait_sys
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_sys(1'b1, 40, cyc);
        chk("por_hold", 32'h1, 32'(cyc >= POWER_UP_TIMER));
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_reset", 32'h0000_0020, rd);
        apb(1'b1, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0023, rd, err);
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_write", 32'h0000_0023, rd);
        apb(1'b0, 8'h08, 32'h0000_0000, rd, err);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        // Glitch then long pin reset
        pin_hold_low <= 1'b1;
        repeat (2) @(posedge clk);
        pin_hold_low <= 1'b0;
        repeat (6) @(posedge clk);
        chk("glitch", 32'h1, {31'h0, sys_reset_n});
        pin_hold_low <= 1'b1;
        repeat (10) @(posedge clk);
        chk("pin_reset", 32'h0, {31'h0, sys_reset_n});
        chk("pin_undriven", 32'h0, {31'h0, pin_oe});
        chk("pin_out_high", 32'h1, {31'h0, pin_out});
        pin_hold_low <= 1'b0;
        wait_sys(1'b1, 5, cyc);
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_pin", 32'h0000_0023, rd);
        // Brown-out, second dip while the timer counts
        dip <= 1'b1;
        repeat (15) @(posedge clk);
        chk("bor_reset", 32'h0, {31'h0, sys_reset_n});
        dip <= 1'b0;
        repeat (6) @(posedge clk);
        dip <= 1'b1;
        repeat (15) @(posedge clk);
        dip <= 1'b0;
        wait_sys(1'b1, 40, cyc);
        chk("bor_timer", 32'h1, 32'(cyc >= POWER_UP_TIMER));
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_bor", 32'h0000_0022, rd);
        apb(1'b1, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0023, rd, err);
        // Regulator off ignores the sag
        regulator_enable_pin <= 1'b0;
        dip <= 1'b1;
        repeat (15) @(posedge clk);
        chk("bor_off", 32'h1, {31'h0, sys_reset_n});
        dip <= 1'b0;
        regulator_enable_pin <= 1'b1;
        // Corrupted shadow copy
        config_shadow <= 16'hedca;
        repeat (2) @(posedge clk);
        chk("cm_reload", 32'h1, {31'h0, config_reload});
        repeat (8) @(posedge clk);
        chk("cm_reset", 32'h0, {31'h0, sys_reset_n});
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_cm", 32'h0000_0003, rd);
        config_shadow <= 16'hedcb;
        wait_sys(1'b1, 10, cyc);
        // Power-on reset in mid-run, pin held low past the timer
        pin_hold_low <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("por_reload", 32'h1, {31'h0, config_reload});
        apb(1'b0, RESET_CONTROL_REGISTER_ADDR, 32'h0000_0000, rd, err);
        chk("reset_control_register_por", 32'h0000_0020, rd);
        repeat (20) @(posedge clk);
        chk("pin_past_timer", 32'h0, {31'h0, sys_reset_n});
        pin_hold_low <= 1'b0;
        wait_sys(1'b1, 10, cyc);
        chk("pin_release", 32'h1, 32'(cyc <= 4));
        end_sim();
    end
endmodule : tb
